// file: src/bsq_sequencer.sv
// Buck switch mode sequencer top module.
`timescale 1ns/1ps
`include "bsq_regs.svh"
module bsq_sequencer
    import bsq_pkg::*;
#(
    parameter int EXIT_CYCLES = `BSQ_EXIT_CYCLES
)(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        thermal_fault_i,
    input  wire logic [1:0]  mode_code_i,
    input  wire bsq_cmp_type cmp_i,
    output logic             hs_gate_o,
    output logic             ls_gate_o,
    output logic [1:0]       sink_step_o,
    output logic             startup_o
);
    if (EXIT_CYCLES < 1 || EXIT_CYCLES > 8191)
    begin : g_bad_exit
        $error("EXIT_CYCLES out of range");
    end

    localparam logic [12:0] EXIT_CNT = 13'(EXIT_CYCLES);

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    bsq_cmp_type cmp_s1_ff, cmp_ff;
    logic [1:0]  mode_s1_ff, mode_ff;
    logic        therm_s1_ff, therm_ff;

    // The synchronisers run through enable low, so the mode is settled when it rises.
    always_ff @(posedge clk_i)
    begin
        cmp_s1_ff   <= cmp_i;
        cmp_ff      <= cmp_s1_ff;
        mode_s1_ff  <= mode_code_i;
        mode_ff     <= mode_s1_ff;
        therm_s1_ff <= thermal_fault_i;
        therm_ff    <= therm_s1_ff;
    end

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    bsq_state_type state_ff, nxt_state;
    logic [7:0]    cnt_ff, nxt_cnt;
    logic [7:0]    sink_cnt_ff, nxt_sink_cnt;
    logic [1:0]    sink_ff, nxt_sink;
    logic [12:0]   exit_cnt_ff, nxt_exit_cnt;
    logic          mono_ff, nxt_mono;
    logic          first_ff, nxt_first;
    logic          early_ff, nxt_early;
    logic          hs_ff, nxt_hs;
    logic          ls_ff, nxt_ls;
    logic [3:0]    idle_ff, nxt_idle;
    logic          skip_ff, nxt_skip;
    logic          phase_ff, nxt_phase;
    logic          skip_sel;

    // The switching clock period is two clk_i cycles; phase marks its halves.
    assign skip_sel = (mode_ff == `BSQ_MODE_SKIP);

    always_comb
    begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_sink_cnt = sink_cnt_ff;
        nxt_sink     = sink_ff;
        nxt_exit_cnt = exit_cnt_ff;
        nxt_mono     = mono_ff;
        nxt_first    = first_ff;
        nxt_early    = early_ff;
        nxt_hs       = 1'b0;
        nxt_ls       = 1'b0;
        nxt_idle     = idle_ff;
        nxt_skip     = skip_ff;
        nxt_phase    = (state_ff == BSQ_RUN) ? ~phase_ff : 1'b0;
        case (state_ff)
            BSQ_OFF:
            begin
                nxt_cnt      = 8'h00;
                nxt_sink_cnt = 8'h00;
                nxt_sink     = 2'h0;
                nxt_exit_cnt = 13'h0000;
                nxt_first    = 1'b1;
                nxt_early    = 1'b0;
                nxt_skip     = 1'b0;
                nxt_idle     = 4'h0;
                nxt_mono     = (mode_ff != `BSQ_MODE_FPWM);
                nxt_state    = BSQ_SETTLE;
            end
            BSQ_SETTLE:
            begin
                nxt_cnt = cnt_ff + 8'h01;
                if (cnt_ff == `BSQ_SETTLE_CYCLES)
                    nxt_state = mono_ff ? BSQ_WAIT : BSQ_RUN;
            end
            BSQ_WAIT:
            begin
                // Both switches stay off until feedback crosses soft-start.
                if (cmp_ff.fb_ss)
                    nxt_state = BSQ_RUN;
            end
            BSQ_RUN:
            begin
                if (sink_cnt_ff != `BSQ_SINK_PERIODS)
                begin
                    nxt_sink_cnt = sink_cnt_ff + 8'h01;
                    // The first step waits two segments, so full comes at 128.
                    if (sink_cnt_ff[4:0] == 5'h1f && sink_cnt_ff[6:5] != 2'h0)
                        nxt_sink = sink_ff + 2'h1;
                end
                if (mono_ff)
                begin
                    if (cmp_ff.fb_good || exit_cnt_ff != 13'h0000)
                        nxt_exit_cnt = exit_cnt_ff + 13'h0001;
                    if (exit_cnt_ff == EXIT_CNT - 13'h0001)
                    begin
                        nxt_mono = 1'b0;
                        nxt_skip = skip_sel;
                    end
                end
                else
                    nxt_skip = skip_sel;
                if (first_ff)
                begin
                    // First period: low side, then high side if it ends early.
                    if (!phase_ff)
                    begin
                        if (cmp_ff.ls_init)
                            nxt_early = 1'b1;
                        else
                            nxt_ls = 1'b1;
                    end
                    else
                    begin
                        nxt_first = 1'b0;
                        if (early_ff && !cmp_ff.hs_peak)
                            nxt_hs = 1'b1;
                    end
                end
                else if (skip_ff)
                begin
                    if (idle_ff > `BSQ_SKIP_IDLE_MAX && !ls_ff)
                    begin
                        nxt_ls   = 1'b1;
                        nxt_idle = 4'h0;
                    end
                    else if (hs_ff && !cmp_ff.hs_peak)
                        nxt_hs = 1'b1;
                    else if (cmp_ff.pwm_on && !ls_ff)
                        nxt_hs = 1'b1;
                    else if (hs_ff || (ls_ff && !cmp_ff.zero_x))
                        nxt_ls = !hs_ff || cmp_ff.pwm_on ? 1'b0 : 1'b1;
                    if (!nxt_hs && idle_ff != 4'hf && !nxt_ls)
                        nxt_idle = idle_ff + 4'h1;
                    else if (nxt_hs)
                        nxt_idle = 4'h0;
                end
                else
                begin
                    // Forced PWM: every period switches, sinking is allowed.
                    if (cmp_ff.pwm_on && !ls_ff)
                        nxt_hs = 1'b1;
                    else if (!cmp_ff.ls_limit && !hs_ff)
                        nxt_ls = 1'b1;
                    nxt_idle = 4'h0;
                end
            end
            default:
            begin
                nxt_state = BSQ_OFF;
            end
        endcase
        if (therm_ff)
        begin
            nxt_state = BSQ_OFF;
            nxt_cnt   = 8'h00;
            nxt_hs    = 1'b0;
            nxt_ls    = 1'b0;
        end
        if (nxt_hs)
            nxt_ls = 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state_ff    <= BSQ_OFF;
            cnt_ff      <= 8'h00;
            sink_cnt_ff <= 8'h00;
            sink_ff     <= 2'h0;
            exit_cnt_ff <= 13'h0000;
            mono_ff     <= 1'b1;
            first_ff    <= 1'b1;
            early_ff    <= 1'b0;
            hs_ff       <= 1'b0;
            ls_ff       <= 1'b0;
            idle_ff     <= 4'h0;
            skip_ff     <= 1'b0;
            phase_ff    <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            sink_cnt_ff <= nxt_sink_cnt;
            sink_ff     <= nxt_sink;
            exit_cnt_ff <= nxt_exit_cnt;
            mono_ff     <= nxt_mono;
            first_ff    <= nxt_first;
            early_ff    <= nxt_early;
            hs_ff       <= nxt_hs;
            ls_ff       <= nxt_ls;
            idle_ff     <= nxt_idle;
            skip_ff     <= nxt_skip;
            phase_ff    <= nxt_phase;
        end
    end

    assign hs_gate_o   = hs_ff;
    assign ls_gate_o   = ls_ff;
    assign sink_step_o = sink_ff;
    assign startup_o   = mono_ff;

endmodule // bsq_sequencer

// file: src/bsq_regs.svh
// Constants of the buck switch mode sequencer.
// ----------------------------------------------------------------------------
// Overview of operation
// - Mode low: forced PWM, no skipped pulses.
// - Mode mid: forced PWM with monotonic startup.
// - First switching action turns low side on.
// - Initial low side ends at period end or 1.35A.
// - Early low-side end: high side until 0.9A.
// - Sink limit rises in four steps over 128.
// - Monotonic startup holds both switches off until the soft-start crossing.
// - With monotonic startup, switching starts when feedback crosses soft-start.
// - Leave monotonic startup 4096 clocks after 92.5%.
// - Mode high: skip at light load, never sink.
// - Skip: idle over eight clocks pulses low side.
// - Skip: low side on for one clock only after high side ends.
// - Skip: high side on at least until 0.9A.
// - Skip at power-up starts monotonic, then skips.
// - Skip and forced PWM change any time after monotonic startup.
// - Enable low holds both switches off.
// - Thermal recovery restarts the full soft-start.
// ----------------------------------------------------------------------------
`ifndef BSQ_REGS_SVH
`define BSQ_REGS_SVH
`define BSQ_SETTLE_CYCLES   8'h10
`define BSQ_SINK_PERIODS    8'h80
`define BSQ_SINK_STEP_CNT   3'h4
`define BSQ_SINK_FULL       2'h3
`define BSQ_EXIT_CYCLES     13'h1000
`define BSQ_SKIP_IDLE_MAX   4'h8
`define BSQ_MODE_FPWM       2'h0
`define BSQ_MODE_MONO       2'h1
`define BSQ_MODE_SKIP       2'h2
`endif

// file: src/bsq_pkg.sv
// Types of the buck switch mode sequencer.
package bsq_pkg;
    typedef enum logic [2:0] {
        BSQ_OFF    = 3'b000,
        BSQ_SETTLE = 3'b001,
        BSQ_WAIT   = 3'b010,
        BSQ_RUN    = 3'b011
    } bsq_state_type;

    typedef struct packed {
        logic ls_limit;   // Low-side sink current at the present limit step.
        logic ls_init;    // Low-side sink current reached 1.35A.
        logic hs_peak;    // Inductor current reached 0.9A.
        logic zero_x;     // Falling inductor current reached 0.2A.
        logic pwm_on;     // Loop comparator asks for a high-side pulse.
        logic fb_ss;      // Feedback level above soft-start level.
        logic fb_good;    // Feedback above 92.5% of the reference level.
    } bsq_cmp_type;
endpackage

// file: test/bsq_sequencer_sva.sv
// Port assertions of the buck switch mode sequencer.
`timescale 1ns/1ps
module bsq_sequencer_sva
    import bsq_pkg::*;
#(
    parameter int EXIT_CYCLES = 4096
)(
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        thermal_fault_i,
    input wire logic [1:0]  mode_code_i,
    input wire bsq_cmp_type cmp_i,
    input wire logic        hs_gate_o,
    input wire logic        ls_gate_o,
    input wire logic [1:0]  sink_step_o,
    input wire logic        startup_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [7:0]  rel_ff, nxt_rel, act_ff, nxt_act;
    logic [12:0] good_ff, nxt_good;
    logic [2:0]  seen_ff, nxt_seen;
    // Seen flags are {any gate, initial sink limit, soft-start crossing}.
    always_comb
    begin
        nxt_rel  = rel_ff + 8'(rel_ff != 8'hff);
        nxt_act  = act_ff + 8'(seen_ff[2] && act_ff != 8'hff);
        nxt_good = cmp_i.fb_good ? good_ff + 13'(good_ff != 13'h1fff) : 13'h0;
        nxt_seen = seen_ff | {hs_gate_o | ls_gate_o, cmp_i.ls_init, cmp_i.fb_ss};
    end
    always_ff @(posedge clk_i)
    begin
        rel_ff  <= rst_n_i ? nxt_rel : 8'h0;
        act_ff  <= rst_n_i ? nxt_act : 8'h0;
        good_ff <= rst_n_i ? nxt_good : 13'h0;
        seen_ff <= rst_n_i ? nxt_seen : 3'h0;
    end
    a_gates_excl: assert property (!(hs_gate_o && ls_gate_o))
        else $error("gate enables high together");
    a_reset_off: assert property ($past(!rst_n_i) |-> !hs_gate_o && !ls_gate_o && sink_step_o == 2'h0)
        else $error("gates or sink step active out of reset");
    a_settle_quiet: assert property (rel_ff < 8'h10 |-> !hs_gate_o && !ls_gate_o)
        else $error("switching before settling");
    a_fault_off: assert property (thermal_fault_i [*5] |-> !hs_gate_o && !ls_gate_o)
        else $error("switching during thermal fault");
    a_first_low: assert property ((hs_gate_o || ls_gate_o) && seen_ff[2:1] == 2'h0 |-> ls_gate_o)
        else $error("first switching action not low side");
    a_prebias_hold: assert property (startup_o && !seen_ff[0] && rel_ff > 8'h2 |-> !hs_gate_o && !ls_gate_o)
        else $error("switching before soft-start crossing");
    a_exit_delay: assert property ($fell(startup_o) && rel_ff > 8'h3 |-> int'(good_ff) >= EXIT_CYCLES)
        else $error("startup left too early");
    a_sink_full: assert property (sink_step_o == 2'h3 |-> act_ff >= 8'h78)
        else $error("full sink limit too early");
    a_sink_order: assert property ($changed(sink_step_o) |-> sink_step_o == $past(sink_step_o) + 2'h1 || sink_step_o == 2'h0)
        else $error("sink step skipped");
endmodule // bsq_sequencer_sva

// file: test/bsq_power_stage.sv
// Behavioural power stage: inductor current and current comparators.
`timescale 1ns/1ps
module bsq_power_stage (
    input  wire logic clk_i,
    input  wire logic hs_i,
    input  wire logic ls_i,
    output logic      ls_limit_o = 1'b0,
    output logic      ls_init_o = 1'b0,
    output logic      hs_peak_o = 1'b0,
    output logic      zero_x_o = 1'b0
);
    int il = 4;
    // Current decays to zero when both switches are off.
    always @(negedge clk_i)
    begin
        il = hs_i ? il + 1 : ls_i ? il - 1 : il - int'(il > 0) + int'(il < 0);
        ls_limit_o = (il <= -6);
        ls_init_o = (il <= -3);
        hs_peak_o = (il >= 9);
        zero_x_o = (il <= 2);
    end
endmodule // bsq_power_stage

// file: test/bsq_sequencer_bench.sv
// Self-checking bench of the buck switch mode sequencer.
`timescale 1ns/1ps
module bsq_sequencer_bench;
    import bsq_pkg::*;
    localparam int EXIT = 16;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        fault = 1'b0;
    logic [1:0]  mode = 2'h0;
    logic        pwm_en = 1'b0;
    logic        fb_ss = 1'b0;
    logic        fb_good = 1'b0;
    logic [3:0]  cyc = 4'h0;
    logic [3:0]  pm;
    logic        hs, ls, st;
    logic [1:0]  sink;
    bsq_cmp_type cmp;
    int          nh = 0;
    int          nl = 0;
    int          n_fail = 0;
    int          cmp_count = 0;
    always #25 clk_i = ~clk_i;
    always @(negedge clk_i) cyc <= cyc + 4'h1;
    always @(posedge clk_i)
    begin
        nh <= nh + int'(hs);
        nl <= nl + int'(ls);
    end
    assign cmp = {pm, pwm_en & cyc[1], fb_ss, fb_good};
    bsq_sequencer #(.EXIT_CYCLES(EXIT)) i_bsq_sequencer (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .thermal_fault_i(fault), .mode_code_i(mode), .cmp_i(cmp), .hs_gate_o(hs),
        .ls_gate_o(ls), .sink_step_o(sink), .startup_o(st));
    bsq_power_stage i_bsq_power_stage (.clk_i(clk_i), .hs_i(hs), .ls_i(ls),
        .ls_limit_o(pm[3]), .ls_init_o(pm[2]), .hs_peak_o(pm[1]), .zero_x_o(pm[0]));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic restart(input logic [1:0] m);
        rst_n_i = 1'b0;
        mode = m;
        fb_ss = 1'b0;
        fb_good = 1'b0;
        pwm_en = 1'b1;
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
    endtask
    task automatic quiet(input string what, input int n);
        int a;
        a = nh + nl;
        repeat (n) @(negedge clk_i);
        chk(what, 8'h0, 8'(nh + nl - a));
    endtask
    task automatic first_gate();
        for (int i = 0; i < 40 && !(hs || ls); i++)
            @(negedge clk_i);
        chk("first gate", 8'h1, {7'h0, ls});
    endtask
    task automatic watch(input string what, input int b, input int n, input logic [7:0] exp);
        logic s;
        s = 1'b0;
        repeat (n)
        begin
            @(negedge clk_i);
            s = s | pm[b];
        end
        chk(what, exp, {7'h0, s});
    endtask
    task automatic t_fpwm();
        int a;
        restart(2'h0);
        quiet("settle", 15);
        first_gate();
        chk("startup", 8'h0, {7'h0, st});
        a = nh;
        repeat (80) @(negedge clk_i);
        chk("sink step", 8'h1, {6'h0, sink});
        chk("high side", 8'h1, {7'h0, nh > a});
        repeat (60) @(negedge clk_i);
        chk("sink step", 8'h3, {6'h0, sink});
    endtask
    task automatic t_fault();
        fault = 1'b1;
        repeat (4) @(negedge clk_i);
        quiet("fault", 10);
        fault = 1'b0;
        quiet("fault settle", 15);
        first_gate();
    endtask
    task automatic t_mono(input logic [1:0] m);
        restart(m);
        quiet("prebias", 40);
        chk("startup", 8'h1, {7'h0, st});
        fb_ss = 1'b1;
        first_gate();
        fb_good = 1'b1;
        repeat (EXIT - 4) @(negedge clk_i);
        chk("startup", 8'h1, {7'h0, st});
        repeat (12) @(negedge clk_i);
        chk("startup", 8'h0, {7'h0, st});
    endtask
    task automatic t_skip();
        int a;
        t_mono(2'h2);
        watch("peak", 1, 30, 8'h1);
        pwm_en = 1'b0;
        repeat (4) @(negedge clk_i);
        a = nl;
        repeat (30) @(negedge clk_i);
        chk("refresh", 8'h1, {7'h0, nl > a});
        watch("sink limit", 3, 30, 8'h0);
        mode = 2'h0;
        watch("sink limit", 3, 30, 8'h1);
    endtask
    task automatic finish_test();
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        @(negedge clk_i);
        t_fpwm();
        t_fault();
        t_mono(2'h1);
        t_skip();
        finish_test();
    end
    initial
    begin
        repeat (3000) @(posedge clk_i);
        n_fail++;
        finish_test();
    end
endmodule // bsq_sequencer_bench
bind bsq_sequencer bsq_sequencer_sva #(.EXIT_CYCLES(EXIT_CYCLES)) i_bsq_sequencer_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .thermal_fault_i(thermal_fault_i),
    .mode_code_i(mode_code_i), .cmp_i(cmp_i), .hs_gate_o(hs_gate_o), .ls_gate_o(ls_gate_o),
    .sink_step_o(sink_step_o), .startup_o(startup_o));
